/* logic/dsam_mapper.sv */
// Data-space address mapper with page registers, byte lanes and address error detection.
// Assumes the core presents one read and one write access per cycle on the core clock.
// What this block does
// - Reads and writes are translated by two independent address paths.
// - Effective addresses are 16-bit byte addresses over a 64 Kbyte base space.
// - Base address plus page register forms a 24-bit, 16 Mbyte extended address.
// - Accesses outside the 1 Kbyte RAM at 0x1000-0x13FF of page zero read zero and write nothing.
// - Low byte of a word sits at the even address, high byte at odd.
// - Post-increment adds 1 for byte accesses, 2 for word accesses.
// - Byte reads select the byte by address bit 0 onto the low data byte.
// - One word decode with per-lane write strobes; byte writes touch one lane.
// - A word access at an odd address raises an address error trap.
// - Read errors complete the access; write errors suppress the memory write.
// - A byte load into a working register changes only its low byte.
// - Sign-widen and clear-upper-byte operations on a 16-bit value are offered.
// - 0x0000-0x0FFF decodes as the special function register region; unused reads zero.
// - 0x0000-0x1FFF is flagged as reachable by the 13-bit direct field.
// - Base addresses with bit 15 clear map unchanged to extended page zero.
// - Only base addresses with bit 15 set go through the page registers.
// - Upper-half extended address is page bits 8:0 concatenated with the low 15 bits.
// - Both page registers reset to 0x001.
// - An upper-half access with a page of 0x000 raises an address error trap.
// - Software writes of zero to a page register are ignored.
// - With stack frame active, frame and stack pointer accesses use flat base space.
`timescale 1ns/1ps
`default_nettype none
module dsam_mapper (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [3:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic rd_req,
  input wire logic [15:0] rd_ea,
  input wire logic rd_byte,
  input wire logic rd_via_frame_stack,
  input wire logic wr_req,
  input wire logic [15:0] wr_ea,
  input wire logic wr_byte,
  input wire logic wr_via_frame_stack,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] reg_old,
  input wire logic [1:0] ext_op,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic [23:0] rd_xaddr,
  output logic rd_is_sfr,
  output logic rd_is_near,
  output logic [15:0] rd_ea_next,
  output logic [15:0] wr_ea_next,
  output logic [23:0] wr_xaddr,
  output logic wr_done,
  output logic [15:0] reg_new,
  output logic trap_req,
  output logic trap_on_write
);
  typedef struct packed {
    logic [9:0] rpage;
    logic [9:0] wpage;
    logic [15:0] corectl;
    logic [1:0] err_count;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] axrdata;
    logic [1:0] rresp;
    logic crvalid;
    logic [15:0] crdata;
    logic [23:0] rxaddr;
    logic rsfr;
    logic rnear;
    logic [15:0] rnext;
    logic [15:0] wnext;
    logic [23:0] wxaddr;
    logic wdone;
    logic [15:0] regnew;
    logic trap;
    logic trapw;
  } dsam_state_type;

  dsam_state_type st_r, st_nxt;
  // Two byte-wide lanes share one word index, so each lane has its own strobe
  logic [7:0] ram_lo_b_r [dsam_pkg::RAM_WORDS];
  logic [7:0] ram_hi_b_r [dsam_pkg::RAM_WORDS];

  // Flat base space when stack frame active on a frame/stack pointer access
  function automatic logic [23:0] dsam_xlate(input logic [15:0] ea, input logic [9:0] page,
                                             input logic flat);
    if (flat || !ea[15])
      dsam_xlate = {8'h00, ea};
    else
      dsam_xlate = {page[8:0], ea[14:0]};
  endfunction

  function automatic logic dsam_fault(input logic [15:0] ea, input logic byte_op,
                                      input logic [9:0] page, input logic flat);
    dsam_fault = (!byte_op && ea[0])
      || (!flat && ea[15] && page == dsam_pkg::PAGE_ZERO);
  endfunction

  function automatic logic dsam_in_ram(input logic [23:0] xa);
    dsam_in_ram = xa[23:16] == 8'h00 && xa[15:0] >= dsam_pkg::RAM_BASE
      && xa[15:0] < dsam_pkg::RAM_BASE + 16'(2 * dsam_pkg::RAM_WORDS);
  endfunction

  function automatic logic [8:0] dsam_word(input logic [23:0] xa);
    logic [15:0] off;
    off = xa[15:0] - dsam_pkg::RAM_BASE;
    dsam_word = off[9:1];
  endfunction

  logic rd_flat, wr_flat, rd_fault, wr_fault, rd_hit, wr_hit;
  logic [23:0] rx, wx;
  logic [15:0] rword, rsel;
  logic [8:0] ridx, widx;
  logic do_wlo, do_whi;

  always_comb begin
    // Two separate translations, one per address generator
    rd_flat = st_r.corectl[dsam_pkg::SFA_BIT] && rd_via_frame_stack;
    wr_flat = st_r.corectl[dsam_pkg::SFA_BIT] && wr_via_frame_stack;
    rx = dsam_xlate(rd_ea, st_r.rpage, rd_flat);
    wx = dsam_xlate(wr_ea, st_r.wpage, wr_flat);
    rd_fault = rd_req && dsam_fault(rd_ea, rd_byte, st_r.rpage, rd_flat);
    wr_fault = wr_req && dsam_fault(wr_ea, wr_byte, st_r.wpage, wr_flat);
    rd_hit = dsam_in_ram(rx);
    wr_hit = dsam_in_ram(wx);
    ridx = dsam_word(rx);
    widx = dsam_word(wx);
    // Whole word fetched; SFRs and unimplemented space read zero here
    rword = rd_hit ? {ram_hi_b_r[ridx], ram_lo_b_r[ridx]} : 16'h0000;
    rsel = rd_byte ? {8'h00, (rd_ea[0] ? rword[15:8] : rword[7:0])} : rword;
    // Write suppressed on fault, byte lane chosen by bit 0
    do_wlo = wr_req && !wr_fault && wr_hit && (!wr_byte || !wr_ea[0]);
    do_whi = wr_req && !wr_fault && wr_hit && (!wr_byte || wr_ea[0]);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.crvalid = rd_req; // Read completes even when it faults
    st_nxt.crdata = rsel;
    st_nxt.rxaddr = rx;
    st_nxt.rsfr = rd_ea <= dsam_pkg::SFR_LAST;
    st_nxt.rnear = rd_ea <= dsam_pkg::NEAR_LAST;
    st_nxt.rnext = rd_ea + (rd_byte ? 16'h0001 : 16'h0002);
    st_nxt.wnext = wr_ea + (wr_byte ? 16'h0001 : 16'h0002);
    st_nxt.wxaddr = wx;
    st_nxt.wdone = do_wlo || do_whi;
    case (ext_op)
      2'h1: st_nxt.regnew = {reg_old[15:8], rsel[7:0]};
      2'h2: st_nxt.regnew = {{8{reg_old[7]}}, reg_old[7:0]};
      2'h3: st_nxt.regnew = {8'h00, reg_old[7:0]};
      default: st_nxt.regnew = rsel;
    endcase
    // Read fault reported in preference when both ports fault together
    st_nxt.trap = rd_fault || wr_fault;
    st_nxt.trapw = wr_fault && !rd_fault;
    if ((rd_fault || wr_fault) && st_r.err_count != 2'h3)
      st_nxt.err_count = st_r.err_count + 2'h1;

    // AXI4-Lite write side: address and data accepted in either order
    if (s_axil_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axil_awaddr;
      st_nxt.awready = 1'b0;
    end
    if (s_axil_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axil_wdata;
      st_nxt.w_strb = s_axil_wstrb;
      st_nxt.wready = 1'b0;
    end
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = dsam_pkg::RESP_OKAY;
      case ({st_r.aw_addr[3:2], 2'b00})
        dsam_pkg::OFS_READ_PAGE: begin
          if (st_r.w_strb[0] && st_r.w_strb[1] && st_r.w_data[9:0] != dsam_pkg::PAGE_ZERO)
            st_nxt.rpage = st_r.w_data[9:0];
        end
        dsam_pkg::OFS_WRITE_PAGE: begin
          if (st_r.w_strb[0] && st_r.w_strb[1] && st_r.w_data[9:0] != dsam_pkg::PAGE_ZERO)
            st_nxt.wpage = st_r.w_data[9:0];
        end
        dsam_pkg::OFS_CORE_CTRL: begin
          if (st_r.w_strb[0])
            st_nxt.corectl[7:0] = st_r.w_data[7:0];
          if (st_r.w_strb[1])
            st_nxt.corectl[15:8] = st_r.w_data[15:8];
        end
        dsam_pkg::OFS_STATUS: begin
          // Clearing the count loses to a fault in the same cycle
          if (st_r.w_strb[0] && !(rd_fault || wr_fault))
            st_nxt.err_count = 2'h0;
        end
        default: st_nxt.bresp = dsam_pkg::RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axil_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end

    // AXI4-Lite read side
    if (s_axil_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = dsam_pkg::RESP_OKAY;
      case ({s_axil_araddr[3:2], 2'b00})
        dsam_pkg::OFS_READ_PAGE: st_nxt.axrdata = {22'h000000, st_r.rpage};
        dsam_pkg::OFS_WRITE_PAGE: st_nxt.axrdata = {22'h000000, st_r.wpage};
        dsam_pkg::OFS_CORE_CTRL: st_nxt.axrdata = {16'h0000, st_r.corectl};
        dsam_pkg::OFS_STATUS: st_nxt.axrdata = {30'h00000000, st_r.err_count};
        default: begin
          st_nxt.axrdata = 32'h00000000;
          st_nxt.rresp = dsam_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rvalid && s_axil_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.rpage <= dsam_pkg::PAGE_RESET;
      st_r.wpage <= dsam_pkg::PAGE_RESET;
      st_r.corectl <= dsam_pkg::CORE_CTRL_RESET;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Data RAM stays out of the reset path so it can map to block memory
  always_ff @(posedge aclk) begin
    if (do_wlo)
      ram_lo_b_r[widx] <= wr_data[7:0];
    if (do_whi)
      ram_hi_b_r[widx] <= wr_byte ? wr_data[7:0] : wr_data[15:8];
  end

  assign s_axil_awready = st_r.awready;
  assign s_axil_wready = st_r.wready;
  assign s_axil_bresp = st_r.bresp;
  assign s_axil_bvalid = st_r.bvalid;
  assign s_axil_arready = st_r.arready;
  assign s_axil_rdata = st_r.axrdata;
  assign s_axil_rresp = st_r.rresp;
  assign s_axil_rvalid = st_r.rvalid;
  assign rd_valid = st_r.crvalid;
  assign rd_data = st_r.crdata;
  assign rd_xaddr = st_r.rxaddr;
  assign rd_is_sfr = st_r.rsfr;
  assign rd_is_near = st_r.rnear;
  assign rd_ea_next = st_r.rnext;
  assign wr_ea_next = st_r.wnext;
  assign wr_xaddr = st_r.wxaddr;
  assign wr_done = st_r.wdone;
  assign reg_new = st_r.regnew;
  assign trap_req = st_r.trap;
  assign trap_on_write = st_r.trapw;
endmodule
`default_nettype wire

/* logic/dsam_pkg.sv */
// Package for the data-space address mapper: register map, region bounds, widths.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit core data path.
package dsam_pkg;
  localparam int unsigned EA_W = 16;
  localparam int unsigned XA_W = 24;
  localparam int unsigned PAGE_W = 10;
  localparam logic [3:0] OFS_READ_PAGE = 4'h0;
  localparam logic [3:0] OFS_WRITE_PAGE = 4'h4;
  localparam logic [3:0] OFS_CORE_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam logic [9:0] PAGE_RESET = 10'h001;
  localparam logic [9:0] PAGE_ZERO = 10'h000;
  localparam int unsigned SFA_BIT = 2;
  localparam logic [15:0] CORE_CTRL_RESET = 16'h0000;
  localparam logic [15:0] SFR_LAST = 16'h0FFF;
  localparam logic [15:0] NEAR_LAST = 16'h1FFF;
  localparam logic [15:0] IMPL_LAST = 16'hCFFF;
  localparam int unsigned RAM_WORDS = 512;
  localparam int unsigned RAM_AW = 9;
  localparam logic [15:0] RAM_BASE = 16'h1000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* verification/dsam_mapper_props.sv */
// Checker for the mapper's core-side ports: timing, mapping and traps.
// Bound into dsam_mapper; sees that module's ports and nothing else.
`timescale 1ns/1ps
`default_nettype none
module dsam_mapper_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rd_req,
  input wire logic [15:0] rd_ea,
  input wire logic rd_byte,
  input wire logic wr_req,
  input wire logic [15:0] wr_ea,
  input wire logic wr_byte,
  input wire logic rd_valid,
  input wire logic [23:0] rd_xaddr,
  input wire logic rd_is_sfr,
  input wire logic rd_is_near,
  input wire logic [15:0] rd_ea_next,
  input wire logic wr_done,
  input wire logic trap_req,
  input wire logic trap_on_write
);
  logic fault;
  // Page zero cannot be loaded, so only odd word accesses can fault here
  assign fault = (rd_req && !rd_byte && rd_ea[0]) || (wr_req && !wr_byte && wr_ea[0]);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence odd_rd; rd_req && !rd_byte && rd_ea[0]; endsequence
  sequence odd_wr; wr_req && !wr_byte && wr_ea[0]; endsequence
  rd_pulse_a: assert property (rd_valid == $past(rd_req))
    else $error("read answer not one cycle after request");
  ea_step_a: assert property (rd_req |=>
    rd_ea_next == $past(rd_ea) + ($past(rd_byte) ? 16'h0001 : 16'h0002))
    else $error("post-increment step wrong");
  low_map_a: assert property (rd_req && !rd_ea[15] |=> rd_xaddr == {8'h00, $past(rd_ea)})
    else $error("lower half not mapped to page zero");
  up_map_a: assert property (rd_req && rd_ea[15] |=> rd_xaddr[14:0] == $past(rd_ea[14:0]))
    else $error("upper half offset bits lost");
  region_dec_a: assert property (rd_req |=> rd_is_sfr == ($past(rd_ea) <= 16'h0FFF)
    && rd_is_near == ($past(rd_ea) <= 16'h1FFF)) else $error("region flags wrong");
  rd_trap_a: assert property (odd_rd |=> trap_req && !trap_on_write)
    else $error("odd word read did not trap as read");
  wr_trap_a: assert property (odd_wr |=> trap_req && !wr_done)
    else $error("odd word write not trapped or not suppressed");
  trap_cause_a: assert property (trap_req |-> $past(fault))
    else $error("trap without a faulting access");
endmodule
bind dsam_mapper dsam_mapper_props i_props (.*);
`default_nettype wire

/* verification/dsam_core_model.sv */
// Model of the core's address generators, one access per task call.
// Assumes the bench calls acc() sequentially; signals change after aclk edges.
`timescale 1ns/1ps
`default_nettype none
module dsam_core_model (
  input wire logic aclk,
  output logic rd_req,
  output logic [15:0] rd_ea,
  output logic rd_byte,
  output logic rd_via_frame_stack,
  output logic wr_req,
  output logic [15:0] wr_ea,
  output logic wr_byte,
  output logic wr_via_frame_stack,
  output logic [15:0] wr_data,
  output logic [15:0] reg_old,
  output logic [1:0] ext_op
);
  initial begin
    {rd_req, rd_byte, rd_via_frame_stack, wr_req, wr_byte, wr_via_frame_stack} = '0;
    {rd_ea, wr_ea, wr_data, reg_old, ext_op} = '0;
  end
  task automatic acc(input logic w, input logic [15:0] ea, input logic b, input logic f,
                     input logic [15:0] d, input logic [1:0] op);
    @(posedge aclk);
    rd_req <= !w;
    wr_req <= w;
    rd_ea <= ea;
    wr_ea <= ea;
    {rd_byte, wr_byte, rd_via_frame_stack, wr_via_frame_stack} <= {b, b, f, f};
    wr_data <= d;
    reg_old <= 16'h12F0;
    ext_op <= op;
    @(posedge aclk);
    {rd_req, wr_req} <= 2'h0;
    // Released address lines show a changed pattern, never the old value
    rd_ea <= ~ea;
    wr_ea <= ~ea;
    wr_data <= ~d;
  endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench: register bus tasks plus core accesses through the model.
// Assumes the mapper registers its answer to a core request on the taking edge itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [3:0] s_axil_awaddr = 4'h0, s_axil_wstrb = 4'h0, s_axil_araddr = 4'h0;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, rv;
  logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
  logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp, ext_op, rr;
  logic rd_req, rd_byte, rd_via_frame_stack, wr_req, wr_byte, wr_via_frame_stack;
  logic [15:0] rd_ea, wr_ea, wr_data, reg_old, rd_data, rd_ea_next, wr_ea_next, reg_new;
  logic rd_valid, rd_is_sfr, rd_is_near, wr_done, trap_req, trap_on_write;
  logic [23:0] rd_xaddr, wr_xaddr;
  int n_fail = 0, checks_done = 0;
  dsam_mapper i_dsam_mapper (.*);
  dsam_core_model i_dsam_core_model (.*);
  initial forever #50 aclk = ~aclk;
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge aclk);
    {s_axil_awaddr, s_axil_wdata, s_axil_wstrb} <= {a, d, 4'hF};
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      i++;
      if (s_axil_awready) s_axil_awvalid <= 1'h0;
      if (s_axil_wready) s_axil_wvalid <= 1'h0;
    end while (!s_axil_bvalid && i < 50);
    s_axil_bready <= 1'h0;
    rr = s_axil_bresp;
    if (i >= 50) chk(64'h1, 64'h0);
    if (i >= 50) conclude();
  endtask
  task automatic axr(input logic [3:0] a);
    int i = 0;
    @(posedge aclk);
    s_axil_araddr <= a;
    {s_axil_arvalid, s_axil_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      i++;
      if (s_axil_arready) s_axil_arvalid <= 1'h0;
    end while (!s_axil_rvalid && i < 50);
    s_axil_rready <= 1'h0;
    {rr, rv} = {s_axil_rresp, s_axil_rdata};
    if (i >= 50) chk(64'h1, 64'h0);
    if (i >= 50) conclude();
  endtask
  // Outputs stand for one cycle, so they are looked at just after the taking edge
  task automatic core(input logic w, input logic [15:0] ea, input logic b, input logic f,
                      input logic [15:0] d, input logic [1:0] op);
    i_dsam_core_model.acc(w, ea, b, f, d, op);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    axr(4'h0);
    chk(rv, 32'h1);
    axr(4'h4);
    chk(rv, 32'h1);
    axw(4'h0, 32'h0);
    chk(rr, dsam_pkg::RESP_OKAY);
    axr(4'h0);
    chk(rv, 32'h1);
    axw(4'h0, 32'h3);
    axr(4'h2);
    chk({rr, rv}, {dsam_pkg::RESP_OKAY, 32'h3});
    core(1'h1, 16'h1000, 1'h0, 1'h0, 16'hA55A, 2'h0);
    chk(wr_done, 1'h1);
    core(1'h1, 16'h1001, 1'h1, 1'h0, 16'h003C, 2'h0);
    core(1'h0, 16'h1000, 1'h0, 1'h0, 16'h0, 2'h0);
    chk({rd_data, reg_new}, {16'h3C5A, 16'h3C5A});
    core(1'h0, 16'h1001, 1'h1, 1'h0, 16'h0, 2'h1);
    chk({rd_data, reg_new, rd_ea_next}, {16'h003C, 16'h123C, 16'h1002});
    core(1'h0, 16'h1000, 1'h0, 1'h0, 16'h0, 2'h2);
    chk({reg_new, rd_ea_next}, {16'hFFF0, 16'h1002});
    core(1'h0, 16'h1000, 1'h0, 1'h0, 16'h0, 2'h3);
    chk(reg_new, 16'h00F0);
    core(1'h1, 16'h1002, 1'h0, 1'h0, 16'h1234, 2'h0);
    core(1'h1, 16'h1003, 1'h0, 1'h0, 16'hFFFF, 2'h0);
    chk({trap_req, trap_on_write, wr_done}, 3'h6);
    core(1'h0, 16'h1003, 1'h0, 1'h0, 16'h0, 2'h0);
    chk({trap_req, trap_on_write, rd_valid, rd_data}, {3'h5, 16'h1234});
    core(1'h0, 16'h0800, 1'h0, 1'h0, 16'h0, 2'h0);
    chk({trap_req, rd_data, rd_is_sfr, rd_is_near}, {17'h0, 2'h3});
    axr(4'hC);
    chk(rv, 32'h2);
    axw(4'hC, 32'h0);
    axr(4'hC);
    chk(rv, 32'h0);
    core(1'h0, 16'h9234, 1'h0, 1'h0, 16'h0, 2'h0);
    chk({rd_xaddr, rd_data}, {24'h019234, 16'h0});
    core(1'h0, 16'h1234, 1'h0, 1'h0, 16'h0, 2'h0);
    chk(rd_xaddr, 24'h001234);
    core(1'h1, 16'hA000, 1'h0, 1'h0, 16'h5555, 2'h0);
    chk({wr_xaddr, wr_done, wr_ea_next}, {24'h00A000, 1'h0, 16'hA002});
    axw(4'h8, 32'h4);
    core(1'h0, 16'h9234, 1'h0, 1'h1, 16'h0, 2'h0);
    chk(rd_xaddr, 24'h009234);
    core(1'h1, 16'h9234, 1'h0, 1'h0, 16'h0, 2'h0);
    chk(wr_xaddr, 24'h009234);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    axr(4'h0);
    chk(rv, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
